// *** pif_core_model.sv ***
`timescale 1ns/1ps
module pif_core_model #(
  parameter int PC_WIDTH = 13
) (
  input  wire logic                clk_sys_in,
  input  wire logic                rst_in,
  input  wire logic                irq_in,
  input  wire logic                en_in,
  input  wire logic                slow_in,
  output logic                     take_out,
  output logic                     ret_out,
  output logic      [PC_WIDTH-1:0] pc_out,
  output int                       takes_out
);
  logic       busy_q;
  logic [4:0] wait_q;
  // core takes a request, runs a handler, returns after a short or long wait
  always_ff @(posedge clk_sys_in) begin
    take_out <= 1'b0;
    ret_out  <= 1'b0;
    if (rst_in) begin
      busy_q    <= 1'b0;
      wait_q    <= 5'h00;
      takes_out <= 0;
      pc_out    <= '0;
    end else if (!busy_q && irq_in && en_in) begin
      take_out  <= 1'b1;
      busy_q    <= 1'b1;
      wait_q    <= slow_in ? 5'h14 : 5'h02;
      takes_out <= takes_out + 1;
    end else if (busy_q) begin
      wait_q <= wait_q - 5'h01;
      if (wait_q == 5'h00) begin
        ret_out <= 1'b1;
        busy_q  <= 1'b0;
      end
    end else begin
      pc_out <= pc_out + 1'b1; // fetch moves on, so each push differs
    end
  end
endmodule // pif_core_model

// *** pif_flags.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// R1: flags set on their event regardless of enables or global enable
// R2: software should clear a flag before enabling it
// R3: first flag register bit 7 reads zero; bits 6..0 hold seven events
// R4: adc flag sets at conversion end, clears when a conversion starts
// R5: bus collision and serial flags read one while pending
// R6: each capture/compare flag sets on capture or compare match
// R7: timer2 match flag sets on period match and holds until cleared
// R8: timer1 flag sets on rollover and holds until cleared
// R9: second register bit 7 is desaturation; bits 6..5 read zero
// R10: overtemperature flag sets once an overtemperature event occurs
// R11: output overvoltage flag sets on entry or exit edge per selects
// R12: gate drive undervoltage flag sets once lockout occurs
// R13: input overvoltage flag sets on entry or exit edge per selects
// R14: input undervoltage flag sets on entry or recovery edge per selects
// R15: taking an interrupt pushes only the return pc on the stack
// R16: last sixteen ram bytes map to the same place in every bank
// R17: peripheral flags request only with peripheral enable set
// R18: request is or of flag and enable, gated by peripheral and global
// R19: flags reset zero, writable, held until cleared; set wins over clear
// R20: voltage edges compare synchronised level against previous cycle
module pif_flags #(
  parameter int PC_WIDTH    = 13,
  parameter int STACK_DEPTH = 8,
  parameter int STACK_PTR_W = 3
) (
  input  wire logic               clk_sys_in,
  input  wire logic               rst_in,
  // avalon-mm register slave
  input  wire logic [4:0]         avs_address_in,
  input  wire logic               avs_read_in,
  input  wire logic               avs_write_in,
  input  wire logic [31:0]        avs_writedata_in,
  input  wire logic [3:0]         avs_byteenable_in,
  output logic      [31:0]        avs_readdata_out,
  output logic                    avs_waitrequest_out,
  // peripheral events and comparator levels
  input  wire pif_pkg::pif_event_t event_in,
  input  wire pif_pkg::pif_level_t level_in,
  // core side
  input  wire logic               irq_take_in,
  input  wire logic               irq_return_in,
  input  wire logic [PC_WIDTH-1:0] pc_in,
  output logic      [PC_WIDTH-1:0] return_pc_out,
  output logic                    irq_out,
  input  wire logic [1:0]         ram_bank_in,
  input  wire logic [6:0]         ram_offset_in,
  output logic      [8:0]         ram_phys_out
);
  import pif_pkg::*;

  logic [7:0]  core_ctrl_q;
  logic [7:0]  option_q;
  logic [7:0]  enable1_q;
  logic [7:0]  enable2_q;
  logic [7:0]  flags1_q;
  logic [7:0]  flags1_d;
  logic [7:0]  flags2_q;
  logic [7:0]  flags2_d;
  logic [7:0]  edge_sel_q;
  logic [7:0]  set1;
  logic [7:0]  set2;
  logic [7:0]  wr_byte;
  logic [7:0]  rd_byte;
  logic        ack_q;
  logic        bus_req;
  logic        wr_go;
  logic        rd_go;
  logic [31:0] readdata_q;
  logic        irq_q;
  logic [8:0]  ram_phys_q;
  pif_level_t  meta_q;
  pif_level_t  sync_q;
  pif_level_t  prev_q;
  logic        out_ov_edge;
  logic        in_ov_edge;
  logic        in_uv_edge;
  logic [PC_WIDTH-1:0]    stack_q [STACK_DEPTH];
  logic [STACK_PTR_W-1:0] sp_q;
  logic [STACK_PTR_W-1:0] sp_top;

  // bus handshake: one wait cycle, then the access completes
  assign bus_req             = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = bus_req & ~ack_q;
  assign wr_go               = avs_write_in & ack_q & avs_byteenable_in[0];
  assign rd_go               = avs_read_in & ~ack_q;
  assign wr_byte             = avs_writedata_in[7:0];
  assign avs_readdata_out    = readdata_q;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    case (avs_address_in)
      PIF_CORE_CTRL_OFS: rd_byte = core_ctrl_q;
      PIF_OPTION_OFS:    rd_byte = option_q;
      PIF_ENABLE1_OFS:   rd_byte = enable1_q;
      PIF_ENABLE2_OFS:   rd_byte = enable2_q;
      PIF_FLAGS1_OFS:    rd_byte = flags1_q & PIF_BANK1_MASK; // R3
      PIF_FLAGS2_OFS:    rd_byte = flags2_q & PIF_BANK2_MASK; // R9
      PIF_EDGE_SEL_OFS:  rd_byte = edge_sel_q;
      default:           rd_byte = 8'h00;
    endcase
  end

  // read data captured in the wait cycle so it is stable at the ack edge
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      readdata_q <= 32'h0000_0000;
    end else if (rd_go) begin
      readdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // core control: global enable drops on entry, returns on exit
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      core_ctrl_q <= PIF_REG_RESET;
    end else begin
      if (wr_go && avs_address_in == PIF_CORE_CTRL_OFS) begin
        core_ctrl_q <= wr_byte;
      end
      if (irq_take_in) begin
        core_ctrl_q[PIF_GIE_BIT] <= 1'b0;
      end else if (irq_return_in) begin
        core_ctrl_q[PIF_GIE_BIT] <= 1'b1;
      end
    end
  end

  // plain software registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      option_q   <= PIF_REG_RESET;
      enable1_q  <= PIF_REG_RESET;
      enable2_q  <= PIF_REG_RESET;
      edge_sel_q <= PIF_EDGE_SEL_RST;
    end else if (wr_go) begin
      case (avs_address_in)
        PIF_OPTION_OFS:   option_q   <= wr_byte;
        PIF_ENABLE1_OFS:  enable1_q  <= wr_byte & PIF_BANK1_MASK;
        PIF_ENABLE2_OFS:  enable2_q  <= wr_byte & PIF_BANK2_MASK;
        PIF_EDGE_SEL_OFS: edge_sel_q <= wr_byte & PIF_EDGE_SEL_MASK;
        default:          ;
      endcase
    end
  end

  // comparator levels are asynchronous: two flops before any logic
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= level_in;
      sync_q <= meta_q;
      prev_q <= sync_q; // R20
    end
  end

  // selected-polarity edge detection on the synchronised levels
  assign out_ov_edge =
    (edge_sel_q[PIF_OUT_OV_RISE_BIT] & sync_q.output_ov & ~prev_q.output_ov)
    | (edge_sel_q[PIF_OUT_OV_FALL_BIT] & ~sync_q.output_ov
       & prev_q.output_ov); // R11
  assign in_ov_edge =
    (edge_sel_q[PIF_IN_OV_RISE_BIT] & sync_q.input_ov & ~prev_q.input_ov)
    | (edge_sel_q[PIF_IN_OV_FALL_BIT] & ~sync_q.input_ov
       & prev_q.input_ov); // R13
  assign in_uv_edge =
    (edge_sel_q[PIF_IN_UV_RISE_BIT] & sync_q.input_uv & ~prev_q.input_uv)
    | (edge_sel_q[PIF_IN_UV_FALL_BIT] & ~sync_q.input_uv
       & prev_q.input_uv); // R14

  // hardware set vectors, independent of any enable
  always_comb begin
    set1                 = 8'h00; // R1
    set1[PIF_ADC_BIT]    = event_in.adc_done; // R4
    set1[PIF_BCOL_BIT]   = event_in.bus_collision; // R5
    set1[PIF_SERIAL_BIT] = event_in.serial_port; // R5
    set1[PIF_CC2_BIT]    = event_in.capcmp_two; // R6
    set1[PIF_CC1_BIT]    = event_in.capcmp_one; // R6
    set1[PIF_T2_BIT]     = event_in.timer2_match; // R7
    set1[PIF_T1_BIT]     = event_in.timer1_rollover; // R8
    set2                 = 8'h00;
    set2[PIF_SWITCH_DESATURATION_BIT]  = event_in.desaturation; // R9
    set2[PIF_OTEMP_BIT]  = event_in.overtemp; // R10
    set2[PIF_OUT_OV_BIT] = out_ov_edge; // R11
    set2[PIF_DRV_UV_BIT] = event_in.gate_drive_uv; // R12
    set2[PIF_IN_OV_BIT]  = in_ov_edge; // R13
    set2[PIF_IN_UV_BIT]  = in_uv_edge; // R14
  end

  // next flag values: software write first, then hardware set on top
  always_comb begin
    flags1_d = flags1_q;
    flags2_d = flags2_q;
    if (wr_go && avs_address_in == PIF_FLAGS1_OFS) begin
      flags1_d = wr_byte; // R19
    end
    if (wr_go && avs_address_in == PIF_FLAGS2_OFS) begin
      flags2_d = wr_byte; // R19
    end
    // a new conversion means no result yet
    if (event_in.adc_start) begin
      flags1_d[PIF_ADC_BIT] = 1'b0; // R4
    end
    // set wins so an event in the clearing cycle is never lost
    flags1_d = (flags1_d | set1) & PIF_BANK1_MASK; // R19
    flags2_d = (flags2_d | set2) & PIF_BANK2_MASK; // R19
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      flags1_q <= PIF_REG_RESET; // R19
      flags2_q <= PIF_REG_RESET; // R19
    end else begin
      flags1_q <= flags1_d;
      flags2_q <= flags2_d;
    end
  end

  // request to the core, registered so the output is glitch free
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= core_ctrl_q[PIF_GIE_BIT] & core_ctrl_q[PIF_PERIPHERAL_IRQ_ENABLE_BIT] // R17
               & (|((flags1_q & enable1_q) | (flags2_q & enable2_q))); // R18
    end
  end
  assign irq_out = irq_q;

  // return stack holds pc only; it wraps like a ring when overrun
  assign sp_top = sp_q - STACK_PTR_W'(1);
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sp_q <= '0;
    end else if (irq_take_in) begin
      stack_q[sp_q] <= pc_in; // R15
      sp_q          <= sp_q + STACK_PTR_W'(1); // R15
    end else if (irq_return_in) begin
      sp_q <= sp_top;
    end
  end

  // stack storage is not reset; only the pointer is
  assign return_pc_out = stack_q[sp_top];

  // common window: top sixteen offsets ignore the bank select
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ram_phys_q <= 9'h000;
    end else if (ram_offset_in >= PIF_COMMON_BASE) begin
      ram_phys_q <= {PIF_COMMON_BANK, ram_offset_in}; // R16
    end else begin
      ram_phys_q <= {ram_bank_in, ram_offset_in};
    end
  end
  assign ram_phys_out = ram_phys_q;

endmodule // pif_flags

// *** pif_flags_assertions.sv ***
`timescale 1ns/1ps
module pif_flags_assertions
  import pif_pkg::*;
#(
  parameter int PC_WIDTH = 13
) (
  input wire logic                clk_sys_in,
  input wire logic                rst_in,
  input wire logic [4:0]          avs_address_in,
  input wire logic                avs_read_in,
  input wire logic                avs_write_in,
  input wire logic [31:0]         avs_readdata_out,
  input wire logic                avs_waitrequest_out,
  input wire logic                irq_take_in,
  input wire logic [PC_WIDTH-1:0] pc_in,
  input wire logic [PC_WIDTH-1:0] return_pc_out,
  input wire logic                irq_out,
  input wire logic [6:0]          ram_offset_in,
  input wire logic [8:0]          ram_phys_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // a request that did not follow a stalled one is a fresh access
  sequence s_new;
    (avs_read_in || avs_write_in) &&
    !($past(avs_read_in || avs_write_in) && $past(avs_waitrequest_out));
  endsequence
  sequence s_one_wait;
    avs_waitrequest_out ##1 !avs_waitrequest_out;
  endsequence
  a_wait_one: assert property (s_new |-> s_one_wait)
    else $error("access did not take one wait cycle");
  a_upper_zero: assert property (avs_readdata_out[31:8] == 24'h0)
    else $error("read data upper bytes not zero");
  a_read_holds: assert property (!avs_read_in |=> $stable(avs_readdata_out))
    else $error("read data moved without a read");
  a_flags1_top: assert property (avs_read_in && avs_waitrequest_out &&
    avs_address_in == PIF_FLAGS1_OFS |=> avs_readdata_out[7] == 1'b0)
    else $error("flags one top bit not zero");
  a_flags2_gap: assert property (avs_read_in && avs_waitrequest_out &&
    avs_address_in == PIF_FLAGS2_OFS |=> avs_readdata_out[6:5] == 2'b00)
    else $error("flags two gap bits not zero");
  a_push_pc: assert property (irq_take_in |=> return_pc_out == $past(pc_in))
    else $error("stack top is not the pushed pc");
  a_take_quiets: assert property (irq_take_in |-> ##[1:3] !irq_out)
    else $error("request stayed up after take");
  a_common_ram: assert property (ram_offset_in >= PIF_COMMON_BASE |=>
    ram_phys_out == {PIF_COMMON_BANK, $past(ram_offset_in)})
    else $error("common ram not bank independent");
  a_reset_quiet: assert property ($fell(rst_in) |-> !irq_out)
    else $error("request high after reset");
endmodule // pif_flags_assertions

bind pif_flags pif_flags_assertions #(.PC_WIDTH(PC_WIDTH)) pif_chk_inst (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .irq_take_in(irq_take_in),
  .pc_in(pc_in), .return_pc_out(return_pc_out), .irq_out(irq_out),
  .ram_offset_in(ram_offset_in), .ram_phys_out(ram_phys_out));

// *** pif_pkg.sv ***
package pif_pkg;

  // register byte addresses on the bus
  localparam logic [4:0] PIF_CORE_CTRL_OFS = 5'h00;
  localparam logic [4:0] PIF_OPTION_OFS    = 5'h04;
  localparam logic [4:0] PIF_ENABLE1_OFS   = 5'h08;
  localparam logic [4:0] PIF_ENABLE2_OFS   = 5'h0C;
  localparam logic [4:0] PIF_FLAGS1_OFS    = 5'h10;
  localparam logic [4:0] PIF_FLAGS2_OFS    = 5'h14;
  localparam logic [4:0] PIF_EDGE_SEL_OFS  = 5'h18;

  // implemented bits of each register
  localparam logic [7:0] PIF_BANK1_MASK    = 8'h7F;
  localparam logic [7:0] PIF_BANK2_MASK    = 8'h9F;
  localparam logic [7:0] PIF_EDGE_SEL_MASK = 8'h3F;

  // reset values
  localparam logic [7:0] PIF_REG_RESET     = 8'h00;
  localparam logic [7:0] PIF_EDGE_SEL_RST  = 8'h15;

  // core control fields
  localparam int PIF_GIE_BIT  = 7;
  localparam int PIF_PERIPHERAL_IRQ_ENABLE_BIT = 6;

  // first flag register fields
  localparam int PIF_ADC_BIT    = 6;
  localparam int PIF_BCOL_BIT   = 5;
  localparam int PIF_SERIAL_BIT = 4;
  localparam int PIF_CC2_BIT    = 3;
  localparam int PIF_CC1_BIT    = 2;
  localparam int PIF_T2_BIT     = 1;
  localparam int PIF_T1_BIT     = 0;

  // second flag register fields
  localparam int PIF_SWITCH_DESATURATION_BIT  = 7;
  localparam int PIF_OTEMP_BIT  = 4;
  localparam int PIF_OUT_OV_BIT = 3;
  localparam int PIF_DRV_UV_BIT = 2;
  localparam int PIF_IN_OV_BIT  = 1;
  localparam int PIF_IN_UV_BIT  = 0;

  // edge select fields
  localparam int PIF_IN_UV_RISE_BIT  = 0;
  localparam int PIF_IN_UV_FALL_BIT  = 1;
  localparam int PIF_IN_OV_RISE_BIT  = 2;
  localparam int PIF_IN_OV_FALL_BIT  = 3;
  localparam int PIF_OUT_OV_RISE_BIT = 4;
  localparam int PIF_OUT_OV_FALL_BIT = 5;

  // shared ram window
  localparam logic [6:0] PIF_COMMON_BASE = 7'h70;
  localparam logic [1:0] PIF_COMMON_BANK = 2'h0;

  // one-cycle event strobes from peripherals on the core clock
  typedef struct packed {
    logic adc_start;
    logic adc_done;
    logic bus_collision;
    logic serial_port;
    logic capcmp_two;
    logic capcmp_one;
    logic timer2_match;
    logic timer1_rollover;
    logic desaturation;
    logic overtemp;
    logic gate_drive_uv;
  } pif_event_t;

  // raw comparator levels arriving from the analog side
  typedef struct packed {
    logic output_ov;
    logic input_ov;
    logic input_uv;
  } pif_level_t;

endpackage

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import pif_pkg::*;
  logic        clk_sys_in, rst_in, rd, wr, irq, wreq, take, ret, en, slow;
  logic [4:0]  adr;
  logic [31:0] wdat, rdat;
  logic [12:0] pc;
  logic [1:0]  bank;
  logic [6:0]  ofs;
  logic [7:0]  d;
  logic [8:0]  phys, e;
  logic [12:0] rpc;
  pif_event_t  ev;
  pif_level_t  lv;
  int          failures, n_checks, takes, n;

  pif_flags pif_flags_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdat), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .event_in(ev),
    .level_in(lv), .irq_take_in(take), .irq_return_in(ret), .pc_in(pc),
    .return_pc_out(rpc), .irq_out(irq), .ram_bank_in(bank),
    .ram_offset_in(ofs), .ram_phys_out(phys));
  pif_core_model pif_core_model_inst (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .irq_in(irq), .en_in(en), .slow_in(slow),
    .take_out(take), .ret_out(ret), .pc_out(pc), .takes_out(takes));

  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // one access; waitrequest and read data are taken at the rising edge
  task bus(input logic w, input logic [4:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    adr  <= a;
    wdat <= {24'h0, v};
    rd   <= !w;
    wr   <= w;
    do @(posedge clk_sys_in); while (wreq !== 1'b0);
    d = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task pulse(input int i);
    @(posedge clk_sys_in);
    ev <= pif_event_t'(11'h1 << i);
    @(posedge clk_sys_in);
    ev <= '0;
  endtask
  task t_regs;
    logic [7:0] m [8];
    m = '{8'hFF, 8'hFF, PIF_BANK1_MASK, PIF_BANK2_MASK, PIF_BANK1_MASK,
          PIF_BANK2_MASK, PIF_EDGE_SEL_MASK, 8'h00};
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 5'(i * 4), 8'h00);
      chk(d, i == 6 ? PIF_EDGE_SEL_RST : PIF_REG_RESET);
      bus(1'b1, 5'(i * 4), 8'hFF);
      bus(1'b0, 5'(i * 4), 8'h00);
      chk(d, m[i]);
      bus(1'b1, 5'(i * 4), 8'h00);
    end
    $display("register test done");
  endtask
  // every event but adc_start, with all enables off, lands in its own flag bit only; adc_start clears the adc flag
  task t_events;
    logic [4:0] a;
    for (int i = 0; i < 10; i++) begin
      a = i > 2 ? PIF_FLAGS1_OFS : PIF_FLAGS2_OFS;
      pulse(i);
      bus(1'b0, a, 8'h00);
      chk(d, i > 2 ? 8'h01 << (i - 3) : i == 2 ? 8'h80 : i == 1 ? 8'h10 : 8'h04);
      bus(1'b1, a, 8'h00);
    end
    pulse(9);
    pulse(10);
    bus(1'b0, PIF_FLAGS1_OFS, 8'h00);
    chk(d, 8'h00);
    $display("event test done");
  endtask
  task t_irq;
    for (int j = 0; j < 2; j++) begin
      slow <= j[0];
      bus(1'b1, PIF_FLAGS1_OFS, 8'h00);
      bus(1'b1, PIF_FLAGS2_OFS, 8'h00);
      bus(1'b1, j ? PIF_ENABLE2_OFS : PIF_ENABLE1_OFS, j ? 8'h80 : 8'h01);
      bus(1'b1, PIF_CORE_CTRL_OFS, 8'h80);
      en <= 1'b1;
      pulse(j ? 2 : 3);
      repeat (4) @(posedge clk_sys_in);
      chk(8'(takes - n), 8'h00);
      bus(1'b1, PIF_CORE_CTRL_OFS, 8'hC0);
      for (int k = 0; k < 20 && takes == n; k++) @(posedge clk_sys_in);
      en <= 1'b0;
      chk(8'(takes - n), 8'h01);
      @(negedge clk_sys_in);
      chk(rpc[7:0], pc[7:0]);
      chk(8'(rpc[12:8]), 8'(pc[12:8]));
      n = takes;
      bus(1'b1, PIF_FLAGS1_OFS, 8'h00);
      bus(1'b1, PIF_FLAGS2_OFS, 8'h00);
      repeat (30) @(posedge clk_sys_in);
      bus(1'b0, PIF_CORE_CTRL_OFS, 8'h00);
      chk(d, 8'hC0); // return restores the global enable
      bus(1'b1, PIF_CORE_CTRL_OFS, 8'h00);
      bus(1'b1, j ? PIF_ENABLE2_OFS : PIF_ENABLE1_OFS, 8'h00);
    end
    $display("interrupt test done");
  endtask
  // wrong polarity must stay quiet, right polarity must set
  task t_edges;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, PIF_EDGE_SEL_OFS, (i == 1 || i == 2) ? 8'h15 : 8'h2A);
      bus(1'b1, PIF_FLAGS2_OFS, 8'h00);
      lv <= pif_level_t'(i[0] ? 3'b000 : 3'b111);
      repeat (6) @(posedge clk_sys_in);
      bus(1'b0, PIF_FLAGS2_OFS, 8'h00);
      chk(d, i > 1 ? 8'h0B : 8'h00);
    end
    $display("edge test done");
  endtask
  task t_ram;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_in);
      bank <= 2'(i);
      ofs  <= 7'h6E + 7'(i);
      e = (7'h6E + 7'(i) >= PIF_COMMON_BASE) ?
          {PIF_COMMON_BANK, 7'h6E + 7'(i)} : {2'(i), 7'h6E + 7'(i)};
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk(phys[7:0], e[7:0]);
      chk(8'(phys[8]), 8'(e[8]));
    end
    $display("ram test done");
  endtask
  task stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test;
  end
  initial begin
    {rst_in, rd, wr, en, slow, adr, wdat, bank, ofs} = '0;
    rst_in = 1'b1;
    ev = '0;
    lv = '0;
    {failures, n_checks, n} = '0;
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_regs;
    t_events;
    t_irq;
    t_edges;
    t_ram;
    stop_test;
  end
endmodule // tb
